// ### rtl/interrupt_flag_enable_bank.sv
/*
 * Interrupt request flag and enable bank with core vector request.
 * Assumes the core reads and writes registers over the special-register
 * port, pulses i_irq_ack once per taken vector and that event inputs are
 * one-cycle pulses synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_enable_bank #(
    parameter int PRIMARY_COUNT = irq_bank_pkg::PRIMARY_COUNT,
    parameter int MEMBER_COUNT  = irq_bank_pkg::MEMBER_COUNT
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst_n,
    input  wire logic [3:0]                       i_reg_addr,
    input  wire logic                             i_reg_wr,
    input  wire logic [7:0]                       i_reg_wdata,
    input  wire logic                             i_pin_a,
    input  wire logic                             i_pin_b,
    input  wire irq_bank_pkg::primary_events_type i_primary_evt,
    input  wire irq_bank_pkg::member_events_type  i_member_evt,
    input  wire logic                             i_irq_ack,
    output logic [7:0]                            o_reg_rdata,
    output logic                                  o_irq_req,
    output logic [3:0]                            o_irq_vector
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [PRIMARY_COUNT-1:0] pf;
    logic [PRIMARY_COUNT-1:0] pe;
    logic [MEMBER_COUNT-1:0]  mf;
    logic [MEMBER_COUNT-1:0]  me;
    logic [1:0]               edge_a;
    logic [1:0]               edge_b;
    logic                     global_irq_enable;

    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    wire [7:0] w      = i_reg_wdata;
    wire       wr_edg = i_reg_wr
                        & (i_reg_addr == irq_bank_pkg::IDX_PIN_EDGE_SELECT);
    wire       wr_c0  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_0);
    wire       wr_c1  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_1);
    wire       wr_c2  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_2);
    wire       wr_c3  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_3);
    wire       wr_g0  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_GROUP_0);
    wire       wr_g1  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_GROUP_1);
    wire       wr_g2  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_GROUP_2);
    wire       wr_g3  = i_reg_wr & (i_reg_addr == irq_bank_pkg::IDX_GROUP_3);

    // Per-bit write strobes and write values, primary bank
    wire [PRIMARY_COUNT-1:0] p_wr   = {{2{wr_c3}}, {4{wr_c2}}, {4{wr_c1}},
                                       {3{wr_c0}}};
    wire [PRIMARY_COUNT-1:0] pf_val = {w[5:4], w[7:4], w[7:4], w[6:4]};
    wire [PRIMARY_COUNT-1:0] pe_val = {w[1:0], w[3:0], w[3:0], w[3:1]};

    // Per-bit write strobes and values, members
    wire [MEMBER_COUNT-1:0] m_wr   = {{4{wr_g3}}, {2{wr_g2}}, {2{wr_g1}},
                                      {2{wr_g0}}};
    wire [MEMBER_COUNT-1:0] mf_val = {w[7:4], w[5:4], w[5:4], w[5:4]};
    wire [MEMBER_COUNT-1:0] me_val = {w[3:0], w[1:0], w[1:0], w[1:0]};

    // ------------------------------------------------------------
    // External pins
    // ------------------------------------------------------------
    logic [1:0] pin_hit;
    wire  [1:0] pin_level = {i_pin_b, i_pin_a};
    wire  [3:0] pin_modes = {edge_b, edge_a};

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp = gp + 1) begin : g_pin
            pin_edge_watch u_watch (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_level (pin_level[gp]),
                .i_mode  (pin_modes[2*gp +: 2]),
                .o_hit   (pin_hit[gp])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Group collection: member flag always sets; its group flag only when its enable is on
    // ------------------------------------------------------------
    wire [MEMBER_COUNT-1:0] m_set = i_member_evt;
    wire [MEMBER_COUNT-1:0] m_fwd = m_set & me;
    wire [3:0] grp_set = {|m_fwd[9:6], |m_fwd[5:4], |m_fwd[3:2],
                          |m_fwd[1:0]};

    // ------------------------------------------------------------
    // Primary set pulses
    // ------------------------------------------------------------
    wire [PRIMARY_COUNT-1:0] p_set = {
        i_primary_evt.transfer_error,
        i_primary_evt.transfer_done,
        pin_hit[1],
        i_primary_evt.timebase_b,
        i_primary_evt.timebase_a,
        i_primary_evt.converter_done,
        grp_set,
        i_primary_evt.voice_record,
        i_primary_evt.voice_play,
        pin_hit[0]
    };

    // Service clears the flag whose vector the core was shown
    wire                     ack_ok  = i_irq_ack & o_irq_req;
    wire [PRIMARY_COUNT-1:0] ack_clr =
        ack_ok ? PRIMARY_COUNT'(1) << o_irq_vector
               : {PRIMARY_COUNT{1'b0}};

    // ------------------------------------------------------------
    // Next values; a set event always wins over any clear
    // ------------------------------------------------------------
    wire [PRIMARY_COUNT-1:0] next_pf =
        (((pf & ~p_wr) | (pf_val & p_wr)) & ~ack_clr) | p_set;
    wire [PRIMARY_COUNT-1:0] next_pe = (pe & ~p_wr) | (pe_val & p_wr);
    wire [MEMBER_COUNT-1:0]  next_mf =
        ((mf & ~m_wr) | (mf_val & m_wr)) | m_set;
    wire [MEMBER_COUNT-1:0]  next_me = (me & ~m_wr) | (me_val & m_wr);

    // Software write of the global bit takes precedence over service
    wire next_global = wr_c0 ? w[irq_bank_pkg::POS_GLOBAL_EN]
                             : (global_irq_enable & ~ack_ok);

    // ------------------------------------------------------------
    // Fixed priority select
    // ------------------------------------------------------------
    // Decided on the next state, so the request drops at the very edge
    // that clears the global bit or an enable, never one cycle later
    wire  [PRIMARY_COUNT-1:0] pending      = pf & pe;
    wire  [PRIMARY_COUNT-1:0] next_pending = next_pf & next_pe;
    logic [3:0]               sel;

    always_comb begin
        sel = 4'h0;
        for (int i = PRIMARY_COUNT - 1; i >= 0; i--) begin
            if (next_pending[i]) begin
                sel = 4'(i);
            end
        end
    end

    // Request withdrawn at the edge that takes the service
    wire next_req = next_global & ~ack_ok & (|next_pending);

    // ------------------------------------------------------------
    // Read images; unimplemented bits tied to zero
    // ------------------------------------------------------------
    wire [7:0] img_edg = {4'h0, edge_b, edge_a};
    wire [7:0] img_c0  = {1'b0, pf[2:0], pe[2:0], global_irq_enable};
    wire [7:0] img_c1  = {pf[6:3], pe[6:3]};
    wire [7:0] img_c2  = {pf[10:7], pe[10:7]};
    wire [7:0] img_c3  = {2'b00, pf[12:11], 2'b00, pe[12:11]};
    wire [7:0] img_g0  = {2'b00, mf[1:0], 2'b00, me[1:0]};
    wire [7:0] img_g1  = {2'b00, mf[3:2], 2'b00, me[3:2]};
    wire [7:0] img_g2  = {2'b00, mf[5:4], 2'b00, me[5:4]};
    wire [7:0] img_g3  = {mf[9:6], me[9:6]};

    wire [7:0] rd_mux =
        (i_reg_addr == irq_bank_pkg::IDX_PIN_EDGE_SELECT) ? img_edg :
        (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_0)       ? img_c0  :
        (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_1)       ? img_c1  :
        (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_2)       ? img_c2  :
        (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_3)       ? img_c3  :
        (i_reg_addr == irq_bank_pkg::IDX_GROUP_0)         ? img_g0  :
        (i_reg_addr == irq_bank_pkg::IDX_GROUP_1)         ? img_g1  :
        (i_reg_addr == irq_bank_pkg::IDX_GROUP_2)         ? img_g2  :
        (i_reg_addr == irq_bank_pkg::IDX_GROUP_3)         ? img_g3  :
                                                            8'h00;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pf                <= '0;
            pe                <= '0;
            mf                <= '0;
            me                <= '0;
            edge_a            <= irq_bank_pkg::REG_RESET[1:0];
            edge_b            <= irq_bank_pkg::REG_RESET[1:0];
            global_irq_enable <= 1'b0;
        end else begin
            pf                <= next_pf;
            pe                <= next_pe;
            mf                <= next_mf;
            me                <= next_me;
            global_irq_enable <= next_global;
            if (wr_edg) begin
                edge_a <= w[irq_bank_pkg::POS_PIN_A_EDGE +: 2];
                edge_b <= w[irq_bank_pkg::POS_PIN_B_EDGE +: 2];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_reg_rdata  <= irq_bank_pkg::REG_RESET;
            o_irq_req    <= 1'b0;
            o_irq_vector <= 4'h0;
        end else begin
            o_reg_rdata  <= rd_mux;
            o_irq_req    <= next_req;
            o_irq_vector <= sel;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_global_gate;
        @(posedge i_clk) disable iff (!i_rst_n)
        !global_irq_enable |-> !o_irq_req;
    endproperty
    a_global_gate: assert property (p_global_gate)
        else $error("request raised with global enable clear");

    property p_service_clears_global;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ack_ok && !wr_c0) |=> !global_irq_enable && !o_irq_req;
    endproperty
    a_service_clears_global: assert property (p_service_clears_global)
        else $error("service left global enable set");

    property p_set_wins;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_primary_evt.voice_play |=> pf[irq_bank_pkg::SRC_PLAY];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("play event lost");

    property p_disabled_still_flags;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_primary_evt.converter_done && !pe[irq_bank_pkg::SRC_CONVERTER]
         && !wr_c2)
        |=> pf[irq_bank_pkg::SRC_CONVERTER]
            && !pending[irq_bank_pkg::SRC_CONVERTER];
    endproperty
    a_disabled_still_flags: assert property (p_disabled_still_flags)
        else $error("disabled source not flagged");

    property p_member_routes_group;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_member_evt.low_voltage && me[6])
        |=> pf[irq_bank_pkg::SRC_GROUP_0 + 3] && mf[6];
    endproperty
    a_member_routes_group: assert property (p_member_routes_group)
        else $error("member did not set its group flag");

    property p_group_ack_keeps_member;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ack_ok && o_irq_vector == 4'(irq_bank_pkg::SRC_GROUP_0)
         && mf[0] && !m_wr[0])
        |=> mf[0];
    endproperty
    a_group_ack_keeps_member: assert property (p_group_ack_keeps_member)
        else $error("member flag cleared by service");

    property p_pin_rise;
        @(posedge i_clk) disable iff (!i_rst_n)
        (edge_a == 2'b01 && $rose(i_pin_a) && $past(i_rst_n, 2))
        |=> pf[irq_bank_pkg::SRC_PIN_A];
    endproperty
    a_pin_rise: assert property (p_pin_rise)
        else $error("rising edge on pin a not flagged");

    property p_pin_off;
        @(posedge i_clk) disable iff (!i_rst_n)
        (edge_b == 2'b00 && !pf[irq_bank_pkg::SRC_PIN_B]
         && !p_wr[irq_bank_pkg::SRC_PIN_B])
        |=> !pf[irq_bank_pkg::SRC_PIN_B];
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin b flagged while its edge field is off");

    property p_reserved_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_addr == irq_bank_pkg::IDX_PRIMARY_3)
        |=> o_reg_rdata[7:6] == 2'b00 && o_reg_rdata[3:2] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unimplemented bits read nonzero");

    property p_priority;
        @(posedge i_clk) disable iff (!i_rst_n)
        (pending[irq_bank_pkg::SRC_PIN_A])
        |-> o_irq_vector == 4'(irq_bank_pkg::SRC_PIN_A);
    endproperty
    a_priority: assert property (p_priority)
        else $error("lowest index not chosen");

    property p_request_consistent;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_irq_req |-> global_irq_enable && pending[o_irq_vector];
    endproperty
    a_request_consistent: assert property (p_request_consistent)
        else $error("request without enabled pending source");

    property p_service_clears_flag;
        @(posedge i_clk) disable iff (!i_rst_n)
        (ack_ok && o_irq_vector == 4'(irq_bank_pkg::SRC_PLAY)
         && !i_primary_evt.voice_play && !wr_c0)
        |=> !pf[irq_bank_pkg::SRC_PLAY];
    endproperty
    a_service_clears_flag: assert property (p_service_clears_flag)
        else $error("serviced flag not cleared");

    property p_pin_fall;
        @(posedge i_clk) disable iff (!i_rst_n)
        (edge_b == 2'b10 && $fell(i_pin_b) && $past(i_rst_n, 2))
        |=> pf[irq_bank_pkg::SRC_PIN_B];
    endproperty
    a_pin_fall: assert property (p_pin_fall)
        else $error("falling edge on pin b not flagged");

    property p_edge_reserved_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_reg_addr == irq_bank_pkg::IDX_PIN_EDGE_SELECT)
        |=> o_reg_rdata[7:4] == 4'h0;
    endproperty
    a_edge_reserved_zero: assert property (p_edge_reserved_zero)
        else $error("edge register upper bits read nonzero");

    property p_member_blocked;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_member_evt.compact_timer_p && !me[0] && !m_fwd[1]
         && !pf[irq_bank_pkg::SRC_GROUP_0]
         && !p_wr[irq_bank_pkg::SRC_GROUP_0])
        |=> mf[0] && !pf[irq_bank_pkg::SRC_GROUP_0];
    endproperty
    a_member_blocked: assert property (p_member_blocked)
        else $error("disabled member set its group flag");

endmodule

`default_nettype wire

// ### rtl/irq_bank_pkg.sv
/*
 * Shared constants and types of the interrupt flag and enable bank.
 * Assumes one system clock; every event input is a one-cycle pulse.
 */
package irq_bank_pkg;

    // ------------------------------------------------------------
    // Register indices on the special-register port
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_PIN_EDGE_SELECT = 4'h0;
    localparam logic [3:0] IDX_PRIMARY_0       = 4'h1;
    localparam logic [3:0] IDX_PRIMARY_1       = 4'h2;
    localparam logic [3:0] IDX_PRIMARY_2       = 4'h3;
    localparam logic [3:0] IDX_PRIMARY_3       = 4'h4;
    localparam logic [3:0] IDX_GROUP_0         = 4'h5;
    localparam logic [3:0] IDX_GROUP_1         = 4'h6;
    localparam logic [3:0] IDX_GROUP_2         = 4'h7;
    localparam logic [3:0] IDX_GROUP_3         = 4'h8;
    localparam int         REG_COUNT           = 9;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int         POS_PIN_A_EDGE = 0;
    localparam int         POS_PIN_B_EDGE = 2;
    localparam int         POS_GLOBAL_EN  = 0;
    localparam logic [7:0] REG_RESET      = 8'h00;

    // ------------------------------------------------------------
    // Edge field codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EDGE_OFF     = 2'b00,
        EDGE_RISING  = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_BOTH    = 2'b11
    } edge_mode_type;

    // ------------------------------------------------------------
    // Primary source index, lowest index wins
    // ------------------------------------------------------------
    localparam int SRC_PIN_A      = 0;
    localparam int SRC_PLAY       = 1;
    localparam int SRC_RECORD     = 2;
    localparam int SRC_GROUP_0    = 3;
    localparam int SRC_CONVERTER  = 7;
    localparam int SRC_TIMEBASE_A = 8;
    localparam int SRC_TIMEBASE_B = 9;
    localparam int SRC_PIN_B      = 10;
    localparam int SRC_DMA_DONE   = 11;
    localparam int SRC_DMA_ERROR  = 12;
    localparam int PRIMARY_COUNT  = 13;
    localparam int MEMBER_COUNT   = 10;

    // ------------------------------------------------------------
    // Event carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic serial_b;
        logic serial_a;
        logic eeprom_write;
        logic low_voltage;
        logic periodic_timer_a;
        logic periodic_timer_p;
        logic standard_timer_a;
        logic standard_timer_p;
        logic compact_timer_a;
        logic compact_timer_p;
    } member_events_type;

    typedef struct packed {
        logic voice_play;
        logic voice_record;
        logic converter_done;
        logic timebase_a;
        logic timebase_b;
        logic transfer_done;
        logic transfer_error;
    } primary_events_type;

endpackage

// ### rtl/pin_edge_watch.sv
/*
 * Edge detector for one external request pin.
 * Assumes the pin level is already synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_edge_watch (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_level,
    input  wire logic [1:0] i_mode,
    output logic            o_hit
);

    logic prev;
    logic armed;
    wire  rise = armed & i_level & ~prev;
    wire  fall = armed & ~i_level & prev;

    // ------------------------------------------------------------
    // Previous level; the first sample after reset only arms
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev  <= 1'b0;
            armed <= 1'b0;
        end else begin
            prev  <= i_level;
            armed <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        unique case (irq_bank_pkg::edge_mode_type'(i_mode))
            irq_bank_pkg::EDGE_OFF:     o_hit = 1'b0;
            irq_bank_pkg::EDGE_RISING:  o_hit = rise;
            irq_bank_pkg::EDGE_FALLING: o_hit = fall;
            irq_bank_pkg::EDGE_BOTH:    o_hit = rise | fall;
        endcase
    end

endmodule

`default_nettype wire

// ### tb/core_vector_model.sv
/*
 * Behavioural model of the core side: takes a vector when asked to.
 * Assumes o_irq_req and o_irq_vector are registered on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module core_vector_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_irq_req,
    input  wire logic [3:0] i_irq_vector,
    input  wire logic       i_auto_ack,
    output logic            o_irq_ack,
    output logic [3:0]      o_last_vector,
    output logic [7:0]      o_ack_count
);
    // ------------------------------------------------------------
    // Acknowledge
    // ------------------------------------------------------------
    // One pulse per request; the gap avoids a second take of the same
    // request while the bank is still clearing it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq_ack     <= 1'b0;
            o_last_vector <= 4'h0;
            o_ack_count   <= 8'h00;
        end else begin
            o_irq_ack <= i_auto_ack && i_irq_req && !o_irq_ack;
            if (i_auto_ack && i_irq_req && !o_irq_ack) begin
                o_last_vector <= i_irq_vector;
                o_ack_count   <= o_ack_count + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/interrupt_flag_enable_bank_tb.sv
/*
 * Self-checking bench of the interrupt flag and enable bank.
 * Assumes the core model file is compiled first; inputs change on the
 * falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module interrupt_flag_enable_bank_tb;
    logic                             clk = 1'b0;
    logic                             rst_n = 1'b0;
    logic [3:0]                       reg_addr = 4'h0;
    logic                             reg_wr = 1'b0;
    logic [7:0]                       reg_wdata = 8'h00;
    logic                             pin_a = 1'b0;
    logic                             pin_b = 1'b0;
    irq_bank_pkg::primary_events_type primary_evt = '0;
    irq_bank_pkg::member_events_type  member_evt = '0;
    logic                             irq_ack;
    logic [7:0]                       rdata;
    logic                             irq_req;
    logic [3:0]                       irq_vector;
    logic                             auto_ack = 1'b0;
    logic [3:0]                       last_vector;
    logic [7:0]                       ack_count;
    int                               fails = 0;
    int                               check_count = 0;

    always #2 clk = ~clk;

    interrupt_flag_enable_bank i_interrupt_flag_enable_bank (
        .i_clk(clk), .i_rst_n(rst_n), .i_reg_addr(reg_addr),
        .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_pin_a(pin_a),
        .i_pin_b(pin_b), .i_primary_evt(primary_evt),
        .i_member_evt(member_evt), .i_irq_ack(irq_ack),
        .o_reg_rdata(rdata), .o_irq_req(irq_req),
        .o_irq_vector(irq_vector));

    core_vector_model i_core_vector_model (
        .i_clk(clk), .i_rst_n(rst_n), .i_irq_req(irq_req),
        .i_irq_vector(irq_vector), .i_auto_ack(auto_ack),
        .o_irq_ack(irq_ack), .o_last_vector(last_vector),
        .o_ack_count(ack_count));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic expect8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = idx;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask

    task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = idx;
        @(negedge clk);
        expect8(rdata, exp);
    endtask

    task automatic wait_ack(input logic [7:0] n);
        int k;
        for (k = 0; k < 50 && ack_count !== n; k++) begin
            @(negedge clk);
        end
        if (ack_count !== n) begin
            fails++;
            $display("mismatch at %0t: no vector taken", $time);
            complete_run();
        end
        repeat (2) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_and_masks();
        logic [7:0] mask [9];
        int i;
        mask = '{8'h0f, 8'h7f, 8'hff, 8'hff, 8'h33,
                 8'h33, 8'h33, 8'h33, 8'hff};
        for (i = 0; i < 9; i++) rd(i[3:0], 8'h00);
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        for (i = 0; i < 9; i++) begin
            wr(i[3:0], 8'hff);
            rd(i[3:0], mask[i]);
        end
        for (i = 0; i < 9; i++) wr(i[3:0], 8'h00);
        rd(4'h1, 8'h00);
        expect8({7'h0, irq_req}, 8'h00);
    endtask

    task automatic edge_modes();
        int m;
        int p;
        logic [3:0] idx;
        logic [7:0] bitv;
        for (p = 0; p < 2; p++) begin
            idx  = (p == 0) ? 4'h1 : 4'h3;
            bitv = (p == 0) ? 8'h10 : 8'h80;
            for (m = 0; m < 4; m++) begin
                wr(4'h0, 8'(m << (2 * p)));
                @(negedge clk);
                if (p == 0) pin_a = 1'b1; else pin_b = 1'b1;
                repeat (3) @(negedge clk);
                rd(idx, (m == 1 || m == 3) ? bitv : 8'h00);
                wr(idx, 8'h00);
                if (p == 0) pin_a = 1'b0; else pin_b = 1'b0;
                repeat (3) @(negedge clk);
                rd(idx, (m == 2 || m == 3) ? bitv : 8'h00);
                wr(idx, 8'h00);
            end
        end
        wr(4'h0, 8'h00);
    endtask

    task automatic primary_flags();
        logic [3:0] idx [7];
        logic [7:0] bitv [7];
        int i;
        idx  = '{4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h1, 4'h1};
        bitv = '{8'h20, 8'h10, 8'h40, 8'h20, 8'h10, 8'h40, 8'h20};
        for (i = 0; i < 7; i++) begin
            @(negedge clk);
            primary_evt = 7'(1 << i);
            @(negedge clk);
            primary_evt = '0;
            rd(idx[i], bitv[i]);
            expect8({7'h0, irq_req}, 8'h00);
            wr(idx[i], 8'h00);
        end
    endtask

    task automatic member_flags();
        int k;
        int g;
        logic [3:0] idx;
        logic [7:0] bitv;
        for (k = 0; k < 10; k++) begin
            g    = (k < 6) ? k / 2 : 3;
            idx  = 4'(5 + g);
            bitv = (k < 6) ? 8'(8'h10 << (k % 2)) : 8'(8'h10 << (k - 6));
            @(negedge clk);
            member_evt = 10'(1 << k);
            @(negedge clk);
            member_evt = '0;
            rd(idx, bitv);
            rd(4'h2, 8'h00);
            wr(idx, bitv >> 4);
            @(negedge clk);
            member_evt = 10'(1 << k);
            @(negedge clk);
            member_evt = '0;
            rd(4'h2, 8'(8'h10 << g));
            wr(idx, 8'h00);
            wr(4'h2, 8'h00);
        end
    endtask

    task automatic service_order();
        @(negedge clk);
        primary_evt = 7'b1100000;
        @(negedge clk);
        primary_evt = '0;
        wr(4'h1, 8'h6c);
        repeat (4) @(negedge clk);
        expect8({7'h0, irq_req}, 8'h00);
        wr(4'h1, 8'h6d);
        expect8({7'h0, irq_req}, 8'h01);
        wr(4'h1, 8'h6c);
        expect8({7'h0, irq_req}, 8'h00);
        auto_ack = 1'b1;
        wr(4'h1, 8'h6d);
        wait_ack(8'h01);
        expect8({4'h0, last_vector}, 8'h01);
        rd(4'h1, 8'h4c);
        expect8({7'h0, irq_req}, 8'h00);
        wr(4'h1, 8'h4d);
        wait_ack(8'h02);
        expect8({4'h0, last_vector}, 8'h02);
        rd(4'h1, 8'h0c);
        wr(4'h5, 8'h01);
        wr(4'h2, 8'h01);
        wr(4'h1, 8'h01);
        @(negedge clk);
        member_evt = 10'h001;
        @(negedge clk);
        member_evt = '0;
        wait_ack(8'h03);
        expect8({4'h0, last_vector}, 8'h03);
        rd(4'h2, 8'h01);
        rd(4'h5, 8'h11);
        wr(4'h5, 8'h00);
        auto_ack = 1'b0;
        wr(4'h2, 8'h00);
        wr(4'h1, 8'h00);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        reset_and_masks();
        edge_modes();
        primary_flags();
        member_flags();
        service_order();
        complete_run();
    end
endmodule
`default_nettype wire
